//--- ipf_byte_ser.sv
`timescale 1ns/100ps
`default_nettype none
module ipf_byte_ser (
   input  wire logic                      clock_i,
   input  wire logic                      reset_i,
   input  wire logic [ipf_pkg::WORD_W-1:0] word_i,
   input  wire logic                      word_first_i,
   input  wire logic                      word_last_i,
   input  wire logic                      word_valid_i,
   output logic                           word_ready_o,
   output logic [7:0]                     byte_o,
   output logic                           byte_valid_o,
   output logic                           byte_first_o,
   output logic                           byte_last_o,
   input  wire logic                      byte_ready_i
);
   import ipf_pkg::*;
   logic [15:0] hold;
   logic        low;
   logic        full;
   logic        first;
   logic        last;
   logic [15:0] next_hold;
   logic        next_low;
   logic        next_full;
   logic        next_first;
   logic        next_last;
   logic        take;
   ////////////////////////////////////////////////////////////////////////////////////////////
   assign word_ready_o = !full || (low && byte_ready_i);
   assign take         = word_valid_i && word_ready_o;
   assign byte_valid_o = full;
   assign byte_o       = low ? hold[7:0] : hold[15:8];
   assign byte_first_o = full && !low && first;
   assign byte_last_o  = full && low && last;
   always_comb begin
      next_hold  = hold;
      next_low   = low;
      next_full  = full;
      next_first = first;
      next_last  = last;
      if (full && byte_ready_i) begin
         next_low  = !low;
         next_full = !low;
      end
      if (take) begin
         next_hold  = word_i;
         next_low   = 1'b0;
         next_full  = 1'b1;
         next_first = word_first_i;
         next_last  = word_last_i;
      end
   end
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         hold  <= 16'h0000;
         low   <= 1'b0;
         full  <= 1'b0;
         first <= 1'b0;
         last  <= 1'b0;
      end else begin
         hold  <= next_hold;
         low   <= next_low;
         full  <= next_full;
         first <= next_first;
         last  <= next_last;
      end
   end
endmodule : ipf_byte_ser
`default_nettype wire

//--- ipf_framer.sv
`timescale 1ns/100ps
`default_nettype none
module ipf_framer (
   input  wire logic        clock_i,
   input  wire logic        reset_i,
   input  wire logic        start_i,
   input  wire logic        layout_64_i,
   input  wire logic        set_packet_key_command_i,
   input  wire logic        set_packet_status_command_i,
   input  wire logic        set_end_marker_command_i,
   input  wire logic [15:0] command_data_i,
   input  wire logic [47:0] timestamp_i,
   output logic [5:0]       channel_o,
   input  wire logic [31:0] pressure_i,
   output logic [2:0]       offset_set_o,
   input  wire logic [15:0] time_offset_i,
   input  wire logic [31:0] temperature_i,
   input  wire logic        module_error_i,
   input  wire logic        thermostat_i,
   input  wire logic [3:0]  module_range_i,
   input  wire logic        over_temp_i,
   input  wire logic        purge_stuck_i,
   input  wire logic [1:0]  purge_position_i,
   output logic [7:0]       byte_o,
   output logic             byte_valid_o,
   output logic             byte_first_o,
   output logic             byte_last_o,
   input  wire logic        byte_ready_i,
   output logic [15:0]      payload_bytes_o,
   output logic             busy_o
);
   import ipf_pkg::*;
   ipf_state_t  state;
   logic [7:0]  widx;
   logic [2:0]  set;
   logic [4:0]  sub;
   logic [2:0]  grp;
   logic        mode64;
   logic [47:0] stamp;
   logic [15:0] seq;
   logic [15:0] key;
   logic [15:0] status;
   logic [15:0] endm;
   logic [15:0] plen;
   ipf_state_t  next_state;
   logic [7:0]  next_widx;
   logic [2:0]  next_set;
   logic [4:0]  next_sub;
   logic [2:0]  next_grp;
   logic        next_mode64;
   logic [47:0] next_stamp;
   logic [15:0] next_seq;
   logic [15:0] next_key;
   logic [15:0] next_status;
   logic [15:0] next_endm;
   logic [15:0] next_plen;
   logic [15:0] word;
   logic        word_valid;
   logic        word_ready;
   logic        word_last;
   logic        in_data;
   logic        is_offset;
   logic [3:0]  pk;
   logic [15:0] scan_word;
   logic [7:0]  last_idx;
   ////////////////////////////////////////////////////////////////////////////////////////////
   // word builder
   assign scan_word = {SCAN_TAG, SCAN_RSV, module_error_i, thermostat_i, module_range_i,
                       over_temp_i, purge_stuck_i, purge_position_i};
   assign last_idx   = mode64 ? W64_END : W8_END;
   assign word_last  = widx == last_idx;
   assign word_valid = state == IPF_SEND;
   assign in_data    = widx >= W_DATA && widx <= (mode64 ? W64_DATA_END : W8_DATA_END);
   assign is_offset  = mode64 && sub == 5'h00;
   assign pk         = mode64 ? 4'(sub - 5'h01) : sub[3:0];
   assign channel_o  = {pk[3:1], grp};
   assign offset_set_o = grp;
   always_comb begin
      word = 16'h0000;
      if (in_data) begin
         if (is_offset) begin
            word = time_offset_i;
         end else begin
            word = pk[0] ? pressure_i[15:0] : pressure_i[31:16];
         end
      end else begin
         case (widx)
            W_KEY:    word = 16'(key + {13'h0000, set});
            W_SIZE:   word = mode64 ? SIZE_64CH : SIZE_8CH;
            W_TS_HI:  word = stamp[47:32];
            W_TS_MID: word = stamp[31:16];
            W_TS_LO:  word = stamp[15:0];
            W_STATUS: word = status;
            W_SEQ:    word = seq;
            default: begin
               if (widx == (mode64 ? W64_TEMP_HI : W8_TEMP_HI)) begin
                  word = temperature_i[31:16];
               end else if (widx == (mode64 ? W64_TEMP_LO : W8_TEMP_LO)) begin
                  word = temperature_i[15:0];
               end else if (widx == (mode64 ? W64_SCAN : W8_SCAN)) begin
                  word = scan_word;
               end else begin
                  word = endm;
               end
            end
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////////////////////////
   // configuration commands
   always_comb begin
      next_key    = key;
      next_status = status;
      next_endm   = endm;
      if (set_packet_key_command_i) begin
         next_key = command_data_i;
      end
      if (set_packet_status_command_i) begin
         next_status = command_data_i;
      end
      if (set_end_marker_command_i) begin
         next_endm = command_data_i;
      end
   end
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         key    <= DEF_KEY;
         status <= DEF_STATUS;
         endm   <= DEF_END;
      end else begin
         key    <= next_key;
         status <= next_status;
         endm   <= next_endm;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////////////////
   // packet sequencer
   always_comb begin
      next_state  = state;
      next_widx   = widx;
      next_set    = set;
      next_sub    = sub;
      next_grp    = grp;
      next_mode64 = mode64;
      next_stamp  = stamp;
      next_seq    = seq;
      next_plen   = plen;
      case (state)
         IPF_IDLE: begin
            if (start_i) begin
               next_state  = IPF_SEND;
               next_widx   = W_KEY;
               next_set    = 3'h0;
               next_grp    = 3'h0;
               next_sub    = 5'h00;
               next_mode64 = layout_64_i;
               next_stamp  = timestamp_i;
               next_plen   = layout_64_i ? BYTES_64CH : BYTES_8CH;
            end
         end
         IPF_SEND: begin
            if (word_ready) begin
               next_widx = 8'(widx + 8'h01);
               if (in_data) begin
                  if (mode64 && sub == SUB_LAST) begin
                     next_sub = 5'h00;
                     next_grp = 3'(grp + 3'h1);
                  end else begin
                     next_sub = 5'(sub + 5'h01);
                  end
               end
               if (word_last) begin
                  next_seq  = 16'(seq + 16'h0001);
                  next_widx = W_KEY;
                  next_sub  = 5'h00;
                  if (!mode64 && set != LAST_SET) begin
                     next_set = 3'(set + 3'h1);
                     next_grp = 3'(set + 3'h1);
                  end else begin
                     next_state = IPF_IDLE;
                     next_set   = 3'h0;
                     next_grp   = 3'h0;
                  end
               end
            end
         end
         default: begin
            next_state = IPF_IDLE;
         end
      endcase
   end
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         state  <= IPF_IDLE;
         widx   <= W_KEY;
         set    <= 3'h0;
         sub    <= 5'h00;
         grp    <= 3'h0;
         mode64 <= 1'b0;
         stamp  <= 48'h000000000000;
         seq    <= 16'h0000;
         plen   <= 16'h0000;
      end else begin
         state  <= next_state;
         widx   <= next_widx;
         set    <= next_set;
         sub    <= next_sub;
         grp    <= next_grp;
         mode64 <= next_mode64;
         stamp  <= next_stamp;
         seq    <= next_seq;
         plen   <= next_plen;
      end
   end
   assign payload_bytes_o = plen;
   assign busy_o          = state == IPF_SEND;
   ////////////////////////////////////////////////////////////////////////////////////////////
   // byte serialiser
   ipf_byte_ser u_ser (
      .clock_i      (clock_i),
      .reset_i      (reset_i),
      .word_i       (word),
      .word_first_i (widx == W_KEY),
      .word_last_i  (word_last),
      .word_valid_i (word_valid),
      .word_ready_o (word_ready),
      .byte_o       (byte_o),
      .byte_valid_o (byte_valid_o),
      .byte_first_o (byte_first_o),
      .byte_last_o  (byte_last_o),
      .byte_ready_i (byte_ready_i)
   );
endmodule : ipf_framer
`default_nettype wire

//--- ipf_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module ipf_monitor (
   input wire logic        clock_i,
   input wire logic        reset_i,
   input wire logic        start_i,
   input wire logic        layout_64_i,
   input wire logic [7:0]  byte_o,
   input wire logic        byte_valid_o,
   input wire logic        byte_first_o,
   input wire logic        byte_last_o,
   input wire logic        byte_ready_i,
   input wire logic [15:0] payload_bytes_o,
   input wire logic        busy_o
);
   logic [8:0] idx;
   logic [8:0] next_idx;
   logic       lay;
   logic       next_lay;
   always_comb begin
      next_idx = idx;
      next_lay = lay;
      if (start_i && !busy_o) next_lay = layout_64_i;
      if (byte_valid_o && byte_ready_i) next_idx = byte_last_o ? 9'h000 : idx + 9'h001;
   end
   always_ff @(posedge clock_i) begin
      idx <= reset_i ? 9'h000 : next_idx;
      lay <= reset_i ? 1'b0 : next_lay;
   end
   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);
   a_start_to_byte: assert property (
      start_i && !busy_o |=> busy_o ##1 byte_valid_o) else $error("no byte after start");
   a_first_flag_pos: assert property (
      byte_valid_o |-> byte_first_o == (idx == 9'h000)) else $error("first flag misplaced");
   a_last_flag_pos: assert property (
      byte_valid_o |-> byte_last_o == (idx == (lay ? 9'h125 : 9'h035)))
      else $error("last flag misplaced");
   a_size_high_byte: assert property (
      byte_valid_o && idx == 9'h002 |-> byte_o == 8'h00) else $error("size high byte");
   a_size_low_byte: assert property (
      byte_valid_o && idx == 9'h003 |-> byte_o == (lay ? 8'h93 : 8'h1B))
      else $error("size low byte");
   a_hold_on_stall: assert property (
      byte_valid_o && !byte_ready_i |=> byte_valid_o && $stable(byte_o) && $stable(byte_last_o))
      else $error("byte changed while stalled");
   a_status_tag_bits: assert property (
      byte_valid_o && idx == (lay ? 9'h122 : 9'h032) |-> byte_o[7:2] == 6'h0F)
      else $error("scanner status top bits");
   a_payload_length: assert property (
      $rose(busy_o) |-> payload_bytes_o == (lay ? 16'h0126 : 16'h0036))
      else $error("payload length");
   c_wide_start: cover property (start_i && !busy_o && layout_64_i);
   c_stall: cover property (byte_valid_o && !byte_ready_i);
   c_last: cover property (byte_valid_o && byte_ready_i && byte_last_o);
endmodule : ipf_monitor
bind ipf_framer ipf_monitor u_mon (.clock_i(clock_i), .reset_i(reset_i), .start_i(start_i),
   .layout_64_i(layout_64_i), .byte_o(byte_o), .byte_valid_o(byte_valid_o),
   .byte_first_o(byte_first_o), .byte_last_o(byte_last_o), .byte_ready_i(byte_ready_i),
   .payload_bytes_o(payload_bytes_o), .busy_o(busy_o));
`default_nettype wire

//--- ipf_pkg.sv
package ipf_pkg;
   localparam int          WORD_W      = 16;
   localparam logic [15:0] SIZE_8CH    = 16'h001B;
   localparam logic [15:0] SIZE_64CH   = 16'h0093;
   localparam logic [15:0] BYTES_8CH   = 16'h0036;
   localparam logic [15:0] BYTES_64CH  = 16'h0126;
   localparam logic [15:0] DEF_STATUS  = 16'h0000;
   localparam logic [15:0] DEF_END     = 16'hDEAD;
   localparam logic [15:0] DEF_KEY     = 16'h0000;
   localparam logic [7:0]  W_KEY       = 8'h00;
   localparam logic [7:0]  W_SIZE      = 8'h01;
   localparam logic [7:0]  W_TS_HI     = 8'h02;
   localparam logic [7:0]  W_TS_MID    = 8'h03;
   localparam logic [7:0]  W_TS_LO     = 8'h04;
   localparam logic [7:0]  W_STATUS    = 8'h05;
   localparam logic [7:0]  W_SEQ       = 8'h06;
   localparam logic [7:0]  W_DATA      = 8'h07;
   localparam logic [7:0]  W8_DATA_END = 8'h16;
   localparam logic [7:0]  W8_TEMP_HI  = 8'h17;
   localparam logic [7:0]  W8_TEMP_LO  = 8'h18;
   localparam logic [7:0]  W8_SCAN     = 8'h19;
   localparam logic [7:0]  W8_END      = 8'h1A;
   localparam logic [7:0]  W64_DATA_END = 8'h8E;
   localparam logic [7:0]  W64_TEMP_HI = 8'h8F;
   localparam logic [7:0]  W64_TEMP_LO = 8'h90;
   localparam logic [7:0]  W64_SCAN    = 8'h91;
   localparam logic [7:0]  W64_END     = 8'h92;
   localparam logic [2:0]  LAST_SET    = 3'h7;
   localparam logic [4:0]  SUB_LAST    = 5'h10;
   localparam logic [4:0]  SCAN_RSV    = 5'h0F;
   localparam logic        SCAN_TAG    = 1'b0;
   typedef enum logic [0:0] {IPF_IDLE, IPF_SEND} ipf_state_t;
endpackage : ipf_pkg

//--- ipf_sink.sv
`timescale 1ns/100ps
`default_nettype none
module ipf_sink (
   input  wire logic       clock_i,
   input  wire logic       reset_i,
   input  wire logic       stall_i,
   input  wire logic [7:0] byte_i,
   input  wire logic       valid_i,
   input  wire logic       first_i,
   input  wire logic       last_i,
   output logic            ready_o
);
   logic [9:0] got[$];
   always @(posedge clock_i) begin
      if (reset_i) begin
         ready_o <= 1'b0;
      end else begin
         if (valid_i && ready_o) got.push_back({first_i, last_i, byte_i});
         ready_o <= stall_i ? 1'($urandom) : 1'b1;
      end
   end
endmodule : ipf_sink
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import ipf_pkg::*;
   logic        clock_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        start_i = 1'b0;
   logic        layout_64_i = 1'b0;
   logic        set_packet_key_command_i = 1'b0;
   logic        set_packet_status_command_i = 1'b0;
   logic        set_end_marker_command_i = 1'b0;
   logic        stall = 1'b0;
   logic        module_error_i = 1'b0, thermostat_i = 1'b0, over_temp_i = 1'b0;
   logic        purge_stuck_i = 1'b0, byte_ready_i, byte_valid_o, byte_first_o;
   logic        byte_last_o, busy_o;
   logic [3:0]  module_range_i = 4'h0;
   logic [1:0]  purge_position_i = 2'h0;
   logic [5:0]  channel_o;
   logic [2:0]  offset_set_o;
   logic [7:0]  byte_o;
   logic [15:0] command_data_i = 16'h0000, time_offset_i, payload_bytes_o;
   logic [47:0] timestamp_i = 48'h0;
   logic [31:0] pressure_i, temperature_i = 32'h0;
   logic [15:0] key = 16'h0000, stat = 16'h0000, endm = 16'hDEAD, seq = 16'h0000;
   logic [15:0] salt = 16'h0000;
   int          fails = 0, checks = 0, cyc = 0, r;
   assign pressure_i = {salt, 10'h000, channel_o};
   assign time_offset_i = {salt[12:0], offset_set_o};
   always #5 clock_i = ~clock_i;
   ipf_framer dut (.clock_i, .reset_i, .start_i, .layout_64_i, .set_packet_key_command_i,
      .set_packet_status_command_i, .set_end_marker_command_i, .command_data_i, .timestamp_i,
      .channel_o, .pressure_i, .offset_set_o, .time_offset_i, .temperature_i, .module_error_i,
      .thermostat_i, .module_range_i, .over_temp_i, .purge_stuck_i, .purge_position_i, .byte_o,
      .byte_valid_o, .byte_first_o, .byte_last_o, .byte_ready_i, .payload_bytes_o, .busy_o);
   ipf_sink u_sink (.clock_i, .reset_i, .stall_i(stall), .byte_i(byte_o), .valid_i(byte_valid_o),
      .first_i(byte_first_o), .last_i(byte_last_o), .ready_o(byte_ready_i));
   ////////////////////////////////////////////////////////////////
   task results;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : results
   task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   function logic [15:0] expw(input logic lay, input int n, input int w);
      int          d, g, q, last;
      logic [31:0] f;
      last = lay ? 146 : 26;
      d = w - 7;
      g = lay ? d / 17 : n;
      q = lay ? d % 17 - 1 : d;
      f = {salt, 10'h000, 3'(q / 2), 3'(g)};
      if (w == 0) return key + 16'(lay ? 0 : n);
      if (w == 1) return lay ? 16'h0093 : 16'h001B;
      if (w < 5) return timestamp_i[(4 - w) * 16 +: 16];
      if (w == 5) return stat;
      if (w == 6) return seq + 16'(n);
      if (w == last) return endm;
      if (w == last - 1) return {SCAN_TAG, SCAN_RSV, module_error_i, thermostat_i,
         module_range_i, over_temp_i, purge_stuck_i, purge_position_i};
      if (w == last - 2) return temperature_i[15:0];
      if (w == last - 3) return temperature_i[31:16];
      if (q < 0) return {salt[12:0], 3'(g)};
      return q % 2 == 0 ? f[31:16] : f[15:0];
   endfunction : expw
   task cmd(input int kind, input logic [15:0] v);
      @(posedge clock_i);
      command_data_i <= v;
      set_packet_key_command_i <= kind == 0;
      set_packet_status_command_i <= kind == 1;
      set_end_marker_command_i <= kind == 2;
      @(posedge clock_i);
      {set_packet_key_command_i, set_packet_status_command_i, set_end_marker_command_i} <= 3'h0;
      if (kind == 0) key = v;
      if (kind == 1) stat = v;
      if (kind == 2) endm = v;
   endtask : cmd
   task burst(input logic lay, input logic stl, input logic again);
      int         pkt, total, i, t;
      logic [9:0] b;
      logic [15:0] w;
      pkt = lay ? 294 : 54;
      total = lay ? 294 : 432;
      @(posedge clock_i);
      stall <= stl;
      layout_64_i <= lay;
      start_i <= 1'b1;
      timestamp_i <= 48'({$urandom, $urandom});
      temperature_i <= $urandom;
      salt <= 16'($urandom);
      {module_error_i, thermostat_i, module_range_i, over_temp_i, purge_stuck_i,
         purge_position_i} <= 10'($urandom);
      @(posedge clock_i);
      start_i <= again;
      repeat (40) @(posedge clock_i);
      start_i <= 1'b0;
      t = 0;
      while (u_sink.got.size() < total && t < 4000) begin
         @(posedge clock_i);
         t++;
      end
      repeat (5) @(posedge clock_i);
      chk("busy", 16'(busy_o), 16'h0000);
      chk("payload bytes", payload_bytes_o, lay ? 16'h0126 : 16'h0036);
      chk("byte count", 16'(u_sink.got.size()), 16'(total));
      for (i = 0; i < total && i < u_sink.got.size(); i++) begin
         b = u_sink.got[i];
         w = expw(lay, i / pkt, (i % pkt) / 2);
         chk("byte", 16'(b[7:0]), 16'(i % 2 ? w[7:0] : w[15:8]));
         chk("first", 16'(b[9]), 16'(i % pkt == 0));
         chk("last", 16'(b[8]), 16'(i % pkt == pkt - 1));
      end
      u_sink.got.delete();
      seq = seq + 16'(total / pkt);
   endtask : burst
   ////////////////////////////////////////////////////////////////
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 40000) begin
         fails++;
         results();
      end
   end
   initial begin
      void'($urandom(32'h2b00));
      repeat (20) @(posedge clock_i);
      reset_i <= 1'b0;
      burst(1'b0, 1'b0, 1'b0);
      burst(1'b1, 1'b1, 1'b0);
      for (r = 0; r < 4; r++) begin
         cmd(0, r == 1 ? 16'hFFFB : 16'($urandom));
         cmd(1, 16'($urandom));
         cmd(2, 16'($urandom));
         burst(r % 2 == 0, r > 0, r == 2);
      end
      // reset in mid-burst: outputs drop, configuration and sequence return to defaults
      @(posedge clock_i);
      start_i <= 1'b1;
      @(posedge clock_i);
      start_i <= 1'b0;
      repeat (30) @(posedge clock_i);
      reset_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      reset_i <= 1'b0;
      @(posedge clock_i);
      chk("busy after reset", 16'(busy_o), 16'h0000);
      chk("valid after reset", 16'(byte_valid_o), 16'h0000);
      chk("bytes after reset", payload_bytes_o, 16'h0000);
      u_sink.got.delete();
      key = DEF_KEY;
      stat = DEF_STATUS;
      endm = DEF_END;
      seq = 16'h0000;
      burst(1'b0, 1'b1, 1'b0);
      results();
   end
endmodule : tb_top
`default_nettype wire
